// ### logic/serial_config_port.sv
// Purpose: serial configuration port with a 64-byte register bank
// Assumes: link clock stands still while port select is high
// Notes:   read data comes from the bank, which only changes between frames
//
// Summary of operation
// - select high puts both data outputs high-Z
// - sample on rising, launch on falling edge
// - write commits after edge 16 or 24
// - incomplete writes are dropped entirely
// - default read data leaves on dedicated output
// - three-wire mode keeps dedicated output high-Z
// - instruction byte then one or two bytes
// - instruction bit 7 high means read
// - instruction bit 6 high means two bytes
// - bits 5..0 give first register address
// - second address steps down MSB-first, up LSB-first
// - LSB-first reverses instruction and data bits
// - MSB-first order unless LSB-first set
// - three-wire read drives data pin after instruction
// - writes always use the data pin
// - four-wire read byte justified by order
`timescale 1ns/1ps
module serial_config_port
  import serial_config_pkg::*;
#(
  parameter int NUM_REGS = serial_config_pkg::REG_COUNT
) (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic                          linkClk,
  input  wire logic                          portSelectN,
  input  wire logic                          sdioIn,
  output logic                               sdioOut,
  output logic                               sdioOutEn,
  output logic                               sdoOut,
  output logic                               sdoOutEn,
  input  wire logic                          threeWireSelect,
  input  wire logic                          lsbFirst,
  output logic                               wrStrobe,
  output serial_config_pkg::cfg_write_t      wrEvent
);

  import serial_config_pkg::*;

  if (NUM_REGS < 1 || NUM_REGS > (1 << ADDR_W)) begin : g_bad_regs
    $error("NUM_REGS must fit the 6-bit register address");
  end

  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] mem;
    logic [1:0]                      seen;
    logic                            pend1;
    logic                            wrStrobe;
    cfg_write_t                      wr;
  } bank_state_t;

  link_frame_t  fr_reg;
  link_frame_t  fr_next;
  link_commit_t cm_reg;
  link_commit_t cm_next;
  link_out_t    lo_reg;
  link_out_t    lo_next;
  bank_state_t  bk_reg;
  bank_state_t  bk_next;

  logic [LINK_SYNC-1:0][1:0] cfgSync;
  logic [MCLK_SYNC-1:0][1:0] togSync;
  logic                      lsbSync;
  logic                      threeSync;

  function automatic logic [DATA_W-1:0] rev8(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = v[DATA_W-1-i];
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // mode bits into the link domain
  // --------------------------------------------------------------
  bit_sync #(.WIDTH(2), .STAGES(LINK_SYNC)) u_cfg_sync (
    .clk   (linkClk),
    .srst  (1'b0),
    .aclr  (portSelectN),
    .dIn   ({threeWireSelect, lsbFirst}),
    .stage (cfgSync)
  );

  assign lsbSync   = cfgSync[LINK_SYNC-1][0];
  assign threeSync = cfgSync[LINK_SYNC-1][1];

  // --------------------------------------------------------------
  // link rising edge: shift, decode, commit
  // --------------------------------------------------------------
  always_comb begin
    logic [DATA_W-1:0] sh;
    logic [DATA_W-1:0] byteVal;
    logic [ADDR_W-1:0] addr2;
    sh      = {fr_reg.shift[DATA_W-2:0], sdioIn};
    byteVal = lsbSync ? rev8(sh) : sh;
    addr2   = lsbSync ? fr_reg.addr + 6'h01 : fr_reg.addr - 6'h01;
    fr_next = fr_reg;
    cm_next = cm_reg;
    fr_next.shift = sh;
    if (fr_reg.cnt != CNT_TWO_END) begin
      fr_next.cnt = fr_reg.cnt + 5'h01;
    end
    if (fr_reg.cnt == CNT_INSTR_LAST) begin
      fr_next.instr   = byteVal;
      fr_next.isRead  = byteVal[INS_RW_BIT];
      fr_next.twoByte = byteVal[INS_LEN_BIT];
      fr_next.addr    = byteVal[INS_ADDR_HI:0];
      fr_next.rdByte  = bk_reg.mem[byteVal[INS_ADDR_HI:0]];
    end
    if (fr_reg.cnt == CNT_BYTE1_LAST) begin
      fr_next.byte0 = byteVal;
      if (fr_reg.isRead) begin
        fr_next.rdByte = bk_reg.mem[addr2];
      end else if (!fr_reg.twoByte) begin
        cm_next.slot[0] = '{addr: fr_reg.addr, data: byteVal};
        cm_next.tog[0]  = ~cm_reg.tog[0];
      end
    end
    if (fr_reg.cnt == CNT_BYTE2_LAST && !fr_reg.isRead
        && fr_reg.twoByte) begin
      cm_next.slot[0] = '{addr: fr_reg.addr, data: fr_reg.byte0};
      cm_next.slot[1] = '{addr: addr2, data: byteVal};
      cm_next.tog     = ~cm_reg.tog;
    end
  end

  // frame state restarts whenever select is high
  always_ff @(posedge linkClk or posedge portSelectN) begin
    if (portSelectN) begin
      fr_reg <= '0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  always_ff @(posedge linkClk or posedge srst) begin
    if (srst) begin
      cm_reg <= '0;
    end else begin
      cm_reg <= cm_next;
    end
  end

  // --------------------------------------------------------------
  // link falling edge: read data launch
  // --------------------------------------------------------------
  always_comb begin
    logic [2:0] idx;
    logic       drive;
    logic       bitVal;
    idx    = fr_reg.cnt[2:0];
    drive  = fr_reg.isRead && fr_reg.cnt >= CNT_DATA_START
             && fr_reg.cnt < (fr_reg.twoByte ? CNT_TWO_END : CNT_ONE_END);
    bitVal = lsbSync ? fr_reg.rdByte[idx]
                     : fr_reg.rdByte[3'h7 - idx];
    lo_next.sdoOut    = bitVal;
    lo_next.sdioOut   = bitVal;
    lo_next.sdoOutEn  = drive && !threeSync;
    lo_next.sdioOutEn = drive && threeSync;
  end

  always_ff @(negedge linkClk or posedge portSelectN) begin
    if (portSelectN) begin
      lo_reg <= '0;
    end else begin
      lo_reg <= lo_next;
    end
  end

  assign sdoOut    = lo_reg.sdoOut;
  assign sdoOutEn  = lo_reg.sdoOutEn;
  assign sdioOut   = lo_reg.sdioOut;
  assign sdioOutEn = lo_reg.sdioOutEn;

  // --------------------------------------------------------------
  // system clock: commit toggles into the register bank
  // --------------------------------------------------------------
  bit_sync #(.WIDTH(2), .STAGES(MCLK_SYNC)) u_tog_sync (
    .clk   (mclk),
    .srst  (srst),
    .aclr  (1'b0),
    .dIn   (cm_reg.tog),
    .stage (togSync)
  );

  always_comb begin
    logic [1:0] ev;
    cfg_write_t w;
    bk_next = bk_reg;
    bk_next.wrStrobe = 1'b0;
    w = '0;
    ev = '0;
    for (int i = 0; i < 2; i++) begin
      ev[i] = (togSync[2][i] == togSync[1][i])
              && (togSync[2][i] != bk_reg.seen[i]);
      if (ev[i]) begin
        bk_next.seen[i] = togSync[2][i];
      end
    end
    if (ev[1]) begin
      bk_next.pend1 = 1'b1;
    end
    if (ev[0]) begin
      w = cm_reg.slot[0];
      bk_next.wrStrobe = 1'b1;
    end else if (bk_next.pend1) begin
      w = cm_reg.slot[1];
      bk_next.wrStrobe = 1'b1;
      bk_next.pend1 = 1'b0;
    end
    if (bk_next.wrStrobe) begin
      bk_next.wr = w;
      if (int'(w.addr) < NUM_REGS) begin
        bk_next.mem[w.addr] = w.data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bk_reg <= '0;
    end else begin
      bk_reg <= bk_next;
    end
  end

  assign wrStrobe = bk_reg.wrStrobe;
  assign wrEvent  = bk_reg.wr;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_idle_hiz: assert property (@(posedge mclk) disable iff (srst)
    portSelectN |-> (!sdoOutEn && !sdioOutEn))
    else $error("data outputs driven while select is high");

  a_one_commit: assert property (@(negedge linkClk)
    disable iff (portSelectN || srst)
    (fr_reg.cnt == CNT_ONE_END && $past(fr_reg.cnt) == CNT_BYTE1_LAST
     && !fr_reg.isRead && !fr_reg.twoByte)
    |-> (cm_reg.tog[0] != $past(cm_reg.tog[0])))
    else $error("single-byte write not committed at edge 16");

  a_two_commit: assert property (@(negedge linkClk)
    disable iff (portSelectN || srst)
    (fr_reg.cnt == CNT_TWO_END && $past(fr_reg.cnt) == CNT_BYTE2_LAST
     && !fr_reg.isRead && fr_reg.twoByte)
    |-> (cm_reg.tog == ~$past(cm_reg.tog)))
    else $error("two-byte write not committed at edge 24");

  a_no_early: assert property (@(posedge linkClk)
    disable iff (portSelectN || srst)
    (fr_reg.cnt < CNT_BYTE1_LAST) |=> $stable(cm_reg.tog))
    else $error("write committed before data complete");

  a_addr_step: assert property (@(negedge linkClk)
    disable iff (portSelectN || srst)
    (fr_reg.cnt == CNT_TWO_END && $past(fr_reg.cnt) == CNT_BYTE2_LAST
     && !fr_reg.isRead && fr_reg.twoByte)
    |-> (cm_reg.slot[1].addr == (lsbSync ? cm_reg.slot[0].addr + 6'h01
                                         : cm_reg.slot[0].addr - 6'h01)))
    else $error("second byte address stepped wrongly");

  a_msb_instr: assert property (@(posedge linkClk)
    disable iff (portSelectN || srst)
    (fr_reg.cnt == CNT_INSTR_LAST && !lsbSync)
    |=> (fr_reg.instr == $past(fr_reg.shift[6:0]) * 8'h02
                         + {7'h00, $past(sdioIn)}))
    else $error("instruction not taken MSB first");

  a_four_wire: assert property (@(posedge linkClk)
    disable iff (portSelectN || srst)
    (fr_reg.isRead && fr_reg.cnt == CNT_DATA_START && !threeSync)
    |-> (sdoOutEn && !sdioOutEn))
    else $error("four-wire read not on dedicated output");

  a_three_wire: assert property (@(posedge linkClk)
    disable iff (portSelectN || srst)
    (fr_reg.isRead && fr_reg.cnt == CNT_DATA_START && threeSync)
    |-> (sdioOutEn && !sdoOutEn))
    else $error("three-wire read not on data pin");

  a_one_driver: assert property (@(posedge mclk) disable iff (srst)
    !(sdoOutEn && sdioOutEn))
    else $error("both data outputs enabled");

  a_bank_write: assert property (@(posedge mclk) disable iff (srst)
    wrStrobe |-> (bk_reg.mem[wrEvent.addr] == wrEvent.data))
    else $error("bank not updated with committed byte");

  a_frame_clear: assert property (@(posedge mclk) disable iff (srst)
    portSelectN |-> (fr_reg.cnt == 5'h00))
    else $error("frame counter not cleared by select");

  c_one_write: cover property (@(negedge linkClk)
    fr_reg.cnt == CNT_ONE_END && !fr_reg.isRead && !fr_reg.twoByte);
  c_two_write: cover property (@(negedge linkClk)
    fr_reg.cnt == CNT_TWO_END && !fr_reg.isRead && fr_reg.twoByte);
  c_three_read: cover property (@(negedge linkClk)
    fr_reg.isRead && threeSync && fr_reg.cnt == CNT_ONE_END);
  c_lsb_two: cover property (@(negedge linkClk)
    lsbSync && fr_reg.twoByte && fr_reg.cnt == CNT_TWO_END);

endmodule

// ### logic/serial_config_pkg.sv
// Purpose: shared constants and carrier types of the serial config port
// Assumes: 6-bit register address, 8-bit register data
// Notes:   frame counts are rising link clock edges from select going low
package serial_config_pkg;

  localparam int ADDR_W      = 6;
  localparam int DATA_W      = 8;
  localparam int CNT_W       = 5;
  localparam int REG_COUNT   = 64;
  localparam int MCLK_SYNC   = 3;
  localparam int LINK_SYNC   = 3;

  // --------------------------------------------------------------
  // instruction byte layout
  // --------------------------------------------------------------
  localparam int INS_RW_BIT  = 7;
  localparam int INS_LEN_BIT = 6;
  localparam int INS_ADDR_HI = 5;

  // --------------------------------------------------------------
  // frame edge counts
  // --------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_INSTR_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_DATA_START = 5'h08;
  localparam logic [CNT_W-1:0] CNT_BYTE1_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_ONE_END    = 5'h10;
  localparam logic [CNT_W-1:0] CNT_BYTE2_LAST = 5'h17;
  localparam logic [CNT_W-1:0] CNT_TWO_END    = 5'h18;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cfg_write_t;

  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] instr;
    logic              isRead;
    logic              twoByte;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] byte0;
    logic [DATA_W-1:0] rdByte;
  } link_frame_t;

  typedef struct packed {
    logic [1:0]       tog;
    cfg_write_t [1:0] slot;
  } link_commit_t;

  typedef struct packed {
    logic sdoOut;
    logic sdoOutEn;
    logic sdioOut;
    logic sdioOutEn;
  } link_out_t;

endpackage

// ### logic/bit_sync.sv
// Purpose: multi-stage synchroniser for a group of levels
// Assumes: aclr is a constant-loading asynchronous clear
// Notes:   stage 0 is read only by stage 1
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          aclr,
  input  wire logic [WIDTH-1:0]              dIn,
  output logic      [STAGES-1:0][WIDTH-1:0]  stage
);

  if (STAGES < 2) begin : g_bad_stages
    $error("bit_sync needs at least two stages");
  end

  always_ff @(posedge clk or posedge aclr) begin
    if (aclr) begin
      stage <= '0;
    end else if (srst) begin
      stage <= '0;
    end else begin
      stage <= {stage[STAGES-2:0], dIn};
    end
  end

endmodule

// ### tb/cfg_controller.sv
// Purpose: system controller model on the far side of the serial port
// Assumes: link clock idles low between frames, half period 32 ns
// Notes:   a released data line toggles every cycle
`timescale 1ns/1ps
module cfg_controller (
  output logic      linkClk,
  output logic      portSelectN,
  output logic      ctlSdio,
  input  wire logic sdioWire,
  input  wire logic sdoWire,
  input  wire logic sdioOutEn,
  input  wire logic sdoOutEn
);
  initial begin
    linkClk = 1'b0;
    portSelectN = 1'b1;
    ctlSdio = 1'b0;
  end
  // ------------------------------------------------------------
  // one frame of n rising edges, read bytes and pin misuse back
  // ------------------------------------------------------------
  task automatic frame(input logic lsb, input logic tw,
                       input logic [2:0][7:0] tx, input int n,
                       output logic [1:0][7:0] rx, output logic bad);
    int   k;
    int   p;
    logic rd;
    int   nb;
    rx = '0;
    bad = 1'b0;
    rd = tx[0][7];
    nb = tx[0][6] ? 2 : 1;
    portSelectN = 1'b0;
    for (k = 0; k < n; k++) begin
      if (rd && tw && k >= 8) ctlSdio = ~ctlSdio;
      else ctlSdio = lsb ? tx[k/8][k%8] : tx[k/8][7-k%8];
      #32 linkClk = 1'b1;
      bad = bad | (tw ? sdoOutEn : sdioOutEn);
      if (!rd || k < 8) bad = bad | sdoOutEn | sdioOutEn;
      else if (k < 8 + 8 * nb) begin
        bad = bad | !(tw ? sdioOutEn : sdoOutEn);
        p = (k - 8) % 8;
        if (lsb) rx[(k-8)/8][p] = tw ? sdioWire : sdoWire;
        else rx[(k-8)/8][7-p] = tw ? sdioWire : sdoWire;
      end
      #32 linkClk = 1'b0;
    end
    #32 portSelectN = 1'b1;
    ctlSdio = ~ctlSdio;
  endtask
endmodule

// ### tb/serial_config_port_tb.sv
// Purpose: self-checking bench of the serial configuration port
// Assumes: byte bank resets to zero, controller model drives the link
// Notes:   expected bytes come from a behavioural bank in the bench
`timescale 1ns/1ps
module serial_config_port_tb;
  import serial_config_pkg::*;
  `define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin \
    err_total++; $display("unexpected at %0t: %s", $time, m); end end
  logic       mclk;
  logic       srst;
  logic       linkClk;
  logic       portSelectN;
  logic       ctlSdio;
  logic       sdioWire;
  logic       sdoWire;
  logic       sdioOut;
  logic       sdioOutEn;
  logic       sdoOut;
  logic       sdoOutEn;
  logic       threeWireSelect;
  logic       lsbFirst;
  logic       wrStrobe;
  cfg_write_t wrEvent;
  cfg_write_t expQ[$];
  logic [7:0] bank[64];
  int         err_total = 0;
  int         total_checks = 0;
  int         seed = 9502;
  assign sdioWire = sdioOutEn ? sdioOut : ctlSdio;
  assign sdoWire = sdoOutEn ? sdoOut : ~sdoOut;
  serial_config_port i_dut (.mclk(mclk), .srst(srst), .linkClk(linkClk),
    .portSelectN(portSelectN), .sdioIn(sdioWire), .sdioOut(sdioOut),
    .sdioOutEn(sdioOutEn), .sdoOut(sdoOut), .sdoOutEn(sdoOutEn),
    .threeWireSelect(threeWireSelect), .lsbFirst(lsbFirst),
    .wrStrobe(wrStrobe), .wrEvent(wrEvent));
  cfg_controller i_ctl (.linkClk(linkClk), .portSelectN(portSelectN),
    .ctlSdio(ctlSdio), .sdioWire(sdioWire), .sdoWire(sdoWire),
    .sdioOutEn(sdioOutEn), .sdoOutEn(sdoOutEn));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // write reports against the model
  // ------------------------------------------------------------
  always @(negedge mclk) begin
    if (wrStrobe === 1'b1) begin
      `CHK(expQ.size() > 0, 1'b1, "stray write strobe")
      if (expQ.size() > 0) begin
        `CHK(wrEvent, expQ[0], "write event")
        void'(expQ.pop_front());
      end
    end
  end
  // ------------------------------------------------------------
  // one frame with model update and checks
  // ------------------------------------------------------------
  task automatic xfer(input logic rd, input logic lsb, input logic tw,
                      input logic two, input logic [5:0] a,
                      input logic [7:0] d0, input logic [7:0] d1,
                      input int n);
    logic [5:0]      a2;
    logic [1:0][7:0] rx;
    logic            bad;
    a2 = lsb ? a + 6'h01 : a - 6'h01;
    @(posedge mclk) #2;
    lsbFirst = lsb;
    threeWireSelect = tw;
    repeat (4) @(posedge mclk);
    #2;
    i_ctl.frame(lsb, tw, {d1, d0, rd, two, a}, n, rx, bad);
    if (!rd && n == 16 + 8 * two) begin
      expQ.push_back('{a, d0});
      bank[a] = d0;
      if (two) begin
        expQ.push_back('{a2, d1});
        bank[a2] = d1;
      end
    end
    repeat (20) @(posedge mclk);
    `CHK(bad, 1'b0, "pin enable misuse");
    `CHK({sdoOutEn, sdioOutEn}, 2'b00, "enables while idle");
    `CHK(expQ.size(), 0, "missing write");
    if (rd) begin
      `CHK(rx[0], bank[a], "read byte");
      if (two) `CHK(rx[1], bank[a2], "second byte");
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    results;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int         m;
    int         ra;
    logic [5:0] a;
    logic [7:0] d;
    srst = 1'b1;
    threeWireSelect = 1'b0;
    lsbFirst = 1'b0;
    for (m = 0; m < 64; m++) bank[m] = 8'h00;
    repeat (10) @(posedge mclk);
    #2 srst = 1'b0;
    repeat (6) @(posedge mclk);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 6'h05, 8'h00, 8'h00, 16);
    $display("reset readback done");
    for (m = 0; m < 4; m++) begin
      ra = $random(seed);
      a = ra[5:0];
      d = ra[15:8];
      xfer(1'b0, m[0], m[1], 1'b0, a, d, 8'h00, 16);
      xfer(1'b1, m[0], m[1], 1'b0, a, 8'h00, 8'h00, 16);
    end
    $display("single byte modes done");
    for (m = 0; m < 2; m++) begin
      ra = $random(seed);
      a = m[0] ? 6'h3f : 6'h00;
      xfer(1'b0, m[0], ra[16], 1'b1, a, ra[7:0], ra[15:8], 24);
      xfer(1'b1, m[0], ra[17], 1'b1, a, 8'h00, 8'h00, 24);
    end
    $display("two byte wrap done");
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 6'h2a, 8'h5a, 8'h00, 15);
    xfer(1'b0, 1'b1, 1'b1, 1'b1, 6'h10, 8'ha5, 8'h3c, 23);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 6'h2a, 8'h00, 8'h00, 16);
    xfer(1'b1, 1'b1, 1'b0, 1'b1, 6'h10, 8'h00, 8'h00, 24);
    $display("aborted writes done");
    results;
  end
endmodule
